//--- design/spms_pkg.sv
package spms_pkg;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_DATA = 8'h08;
    localparam logic [7:0] A_PINS = 8'h0c;

    // ****************************************
    // field positions
    // ****************************************
    localparam int B_IE       = 7;
    localparam int B_EN       = 6;
    localparam int B_LSB      = 5;
    localparam int B_MST      = 4;
    localparam int B_CLOCK_IDLE_HIGH     = 3;
    localparam int B_SAMPLE_ON_TRAILING     = 2;
    localparam int B_TRANSFER_DONE_FLAG     = 7;
    localparam int B_WRITE_COLLISION_FLAG     = 6;
    localparam int B_DBL      = 0;
    localparam int B_MOSI_DIR = 0;
    localparam int B_MISO_DIR = 1;
    localparam int B_SCK_DIR  = 2;
    localparam int B_SS_DIR   = 3;
    localparam int B_SS_LVL   = 4;

    // ****************************************
    // reset values and counts
    // ****************************************
    localparam logic [7:0] CTRL_RST  = 8'h00;
    localparam logic [4:0] PINS_RST  = 5'h10;
    localparam logic [3:0] BITS_LAST = 4'h7;
    localparam logic [4:0] EDGE_LAST = 5'h0f;
    localparam int DIV_NORM [4] = '{4, 16, 64, 128};
    localparam int DIV_DBL  [4] = '{2, 8, 32, 64};

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_XFER = 2'b10
    } spms_st_t;

endpackage

//--- design/spms_rate_div.sv
`timescale 1ns/100ps
module spms_rate_div #(
    parameter int CNT_W = 7
) (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // control
    input  wire logic       i_run,
    input  wire logic [1:0] i_rate,
    input  wire logic       i_dbl,
    // half-period enable
    output logic            o_tick
);

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] half;

    // half a serial clock period in system cycles
    always_comb begin
        if (i_dbl) begin
            half = CNT_W'(spms_pkg::DIV_DBL[i_rate] / 2);
        end else begin
            half = CNT_W'(spms_pkg::DIV_NORM[i_rate] / 2);
        end
    end

    assign o_tick = i_run && (cnt_reg == half - CNT_W'(1));

    always_ff @(posedge i_clk) begin
        if (i_rst || !i_run || o_tick) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + CNT_W'(1);
        end
    end

endmodule

//--- design/spms_port.sv
// Implementation choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/100ps
// ****************************************
// ****************************************
module spms_port (
    // clock and reset
    input  wire logic        I_SYS_CLK,
    input  wire logic        I_RST,
    // ahb-lite slave
    input  wire logic        I_HSEL,
    input  wire logic [31:0] I_HADDR,
    input  wire logic [1:0]  I_HTRANS,
    input  wire logic        I_HWRITE,
    input  wire logic [2:0]  I_HSIZE,
    input  wire logic [31:0] I_HWDATA,
    input  wire logic        I_HREADY,
    output logic      [31:0] O_HRDATA,
    output logic             O_HREADYOUT,
    output logic             O_HRESP,
    // cpu interrupt side
    input  wire logic        I_GLOBAL_IRQ_EN,
    input  wire logic        I_IRQ_ACK,
    output logic             O_IRQ,
    // serial pins
    input  wire logic        I_SCK_IN,
    output logic             O_SCK_OUT,
    output logic             O_SCK_OE,
    input  wire logic        I_MOSI_IN,
    output logic             O_MOSI_OUT,
    output logic             O_MOSI_OE,
    input  wire logic        I_MISO_IN,
    output logic             O_MISO_OUT,
    output logic             O_MISO_OE,
    input  wire logic        I_SS_N_IN,
    output logic             O_SS_N_OUT,
    output logic             O_SS_N_OE
);

    logic [7:0]       ctrl_reg;
    logic             dbl_reg;
    logic [4:0]       pins_reg;
    logic             transfer_done_flag_reg;
    logic             write_collision_flag_reg;
    logic             arm_reg;
    logic [7:0]       sh_reg;
    logic [7:0]       rxbuf_reg;
    logic             out_bit_reg;
    logic [3:0]       cnt_reg;
    logic [4:0]       edge_reg;
    logic             sck_in_q;
    logic             ph_wr_reg;
    logic             ph_rd_reg;
    logic [7:0]       ph_addr_reg;
    spms_pkg::spms_st_t st_reg;

    // ****************************************
    // ahb-lite register access
    // ****************************************
    logic acc;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_data;
    logic wr_pins;
    logic rd_stat;
    logic rd_data;
    logic data_acc;
    logic [31:0] rd_mux;

    assign acc      = I_HSEL && I_HTRANS[1] && I_HREADY;
    assign wr_ctrl  = ph_wr_reg && ph_addr_reg == spms_pkg::A_CTRL;
    assign wr_stat  = ph_wr_reg && ph_addr_reg == spms_pkg::A_STAT;
    assign wr_data  = ph_wr_reg && ph_addr_reg == spms_pkg::A_DATA;
    assign wr_pins  = ph_wr_reg && ph_addr_reg == spms_pkg::A_PINS;
    assign rd_stat  = ph_rd_reg && ph_addr_reg == spms_pkg::A_STAT;
    assign rd_data  = ph_rd_reg && ph_addr_reg == spms_pkg::A_DATA;
    assign data_acc = wr_data || rd_data;

    always_comb begin
        unique case (ph_addr_reg)
            spms_pkg::A_CTRL: rd_mux = {24'h000000, ctrl_reg};
            spms_pkg::A_STAT: rd_mux = {24'h000000, transfer_done_flag_reg, write_collision_flag_reg, 5'h00, dbl_reg};
            spms_pkg::A_DATA: rd_mux = {24'h000000, rxbuf_reg};
            spms_pkg::A_PINS: rd_mux = {27'h0000000, pins_reg};
            default:          rd_mux = 32'h00000000;
        endcase
    end

    // reads take one wait state so a preceding write is visible
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            ph_wr_reg   <= 1'b0;
            ph_rd_reg   <= 1'b0;
            ph_addr_reg <= 8'h00;
            O_HREADYOUT <= 1'b1;
            O_HRDATA    <= 32'h00000000;
            O_HRESP     <= 1'b0;
        end else begin
            ph_wr_reg   <= acc && I_HWRITE;
            ph_rd_reg   <= acc && !I_HWRITE;
            O_HREADYOUT <= !(acc && !I_HWRITE);
            if (acc) begin
                ph_addr_reg <= {I_HADDR[7:2], 2'b00};
            end
            if (ph_rd_reg) begin
                O_HRDATA <= rd_mux;
            end
        end
    end

    // ****************************************
    // mode decode
    // ****************************************
    logic en;
    logic clock_idle_high;
    logic sample_on_trailing;
    logic lsbf;
    logic is_mst;
    logic is_slv;
    logic slv_act;
    logic ss_fault;
    logic busy;
    logic start;
    logic tick;

    assign en       = ctrl_reg[spms_pkg::B_EN];
    assign clock_idle_high     = ctrl_reg[spms_pkg::B_CLOCK_IDLE_HIGH];
    assign sample_on_trailing     = ctrl_reg[spms_pkg::B_SAMPLE_ON_TRAILING];
    assign lsbf     = ctrl_reg[spms_pkg::B_LSB];
    assign is_mst   = en && ctrl_reg[spms_pkg::B_MST];
    assign is_slv   = en && !ctrl_reg[spms_pkg::B_MST];
    assign slv_act  = is_slv && !I_SS_N_IN;
    assign ss_fault = is_mst && !pins_reg[spms_pkg::B_SS_DIR] && !I_SS_N_IN;
    assign busy     = is_mst ? (st_reg == spms_pkg::ST_XFER) : (cnt_reg != 4'h0);
    assign start    = wr_data && is_mst && !busy;

    spms_rate_div #(
        .CNT_W (7)
    ) u_div (
        .i_clk  (I_SYS_CLK),
        .i_rst  (I_RST),
        .i_run  (is_mst && st_reg == spms_pkg::ST_XFER && !ss_fault),
        .i_rate (ctrl_reg[1:0]),
        .i_dbl  (dbl_reg),
        .o_tick (tick)
    );

    // ****************************************
    // serial clock edges and shifting
    // ****************************************
    logic lead_e;
    logic trail_e;
    logic samp_e;
    logic shft_e;
    logic din;
    logic tx_bit;
    logic done_e;
    logic [7:0] sh_next;

    always_comb begin
        if (is_mst) begin
            lead_e  = tick && !edge_reg[0];
            trail_e = tick && edge_reg[0];
        end else begin
            lead_e  = slv_act && sck_in_q == clock_idle_high && I_SCK_IN != clock_idle_high;
            trail_e = slv_act && sck_in_q != clock_idle_high && I_SCK_IN == clock_idle_high;
        end
    end

    assign samp_e  = sample_on_trailing ? trail_e : lead_e;
    assign shft_e  = sample_on_trailing ? lead_e : trail_e;
    assign din     = is_mst ? I_MISO_IN : I_MOSI_IN;
    assign tx_bit  = lsbf ? sh_reg[0] : sh_reg[7];
    assign sh_next = lsbf ? {din, sh_reg[7:1]} : {sh_reg[6:0], din};
    assign done_e  = samp_e && cnt_reg == spms_pkg::BITS_LAST;

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            sck_in_q <= 1'b0;
        end else begin
            sck_in_q <= I_SCK_IN;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            st_reg   <= spms_pkg::ST_IDLE;
            edge_reg <= 5'h00;
            O_SCK_OUT <= 1'b0;
        end else begin
            unique case (st_reg)
                spms_pkg::ST_IDLE: begin
                    O_SCK_OUT <= clock_idle_high;
                    edge_reg  <= 5'h00;
                    if (start) begin
                        st_reg <= spms_pkg::ST_XFER;
                    end
                end
                spms_pkg::ST_XFER: begin
                    if (ss_fault || !is_mst) begin
                        st_reg <= spms_pkg::ST_IDLE;
                    end else if (tick) begin
                        O_SCK_OUT <= ~O_SCK_OUT;
                        edge_reg  <= edge_reg + 5'h01;
                        if (edge_reg == spms_pkg::EDGE_LAST) begin
                            st_reg <= spms_pkg::ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            cnt_reg <= 4'h0;
        end else if ((is_slv && I_SS_N_IN) || ss_fault || start || !en) begin
            cnt_reg <= 4'h0;
        end else if (samp_e) begin
            cnt_reg <= done_e ? 4'h0 : cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            sh_reg      <= 8'h00;
            out_bit_reg <= 1'b0;
        end else if (wr_data && !busy) begin
            sh_reg      <= I_HWDATA[7:0];
            out_bit_reg <= lsbf ? I_HWDATA[0] : I_HWDATA[7];
        end else begin
            if (samp_e) begin
                sh_reg <= sh_next;
            end
            if (shft_e || !busy) begin
                out_bit_reg <= tx_bit;
            end
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            rxbuf_reg <= 8'h00;
        end else if (done_e) begin
            rxbuf_reg <= sh_next;
        end
    end

    // ****************************************
    // control, status and flags
    // ****************************************
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            ctrl_reg <= spms_pkg::CTRL_RST;
            dbl_reg  <= 1'b0;
            pins_reg <= spms_pkg::PINS_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= I_HWDATA[7:0];
            end
            if (ss_fault) begin
                ctrl_reg[spms_pkg::B_MST] <= 1'b0;
            end
            if (wr_stat) begin
                dbl_reg <= I_HWDATA[spms_pkg::B_DBL];
            end
            if (wr_pins) begin
                pins_reg <= I_HWDATA[4:0];
            end
        end
    end

    // hardware set wins over any clear in the same cycle
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            transfer_done_flag_reg <= 1'b0;
            write_collision_flag_reg <= 1'b0;
            arm_reg  <= 1'b0;
        end else begin
            if (rd_stat && (transfer_done_flag_reg || write_collision_flag_reg)) begin
                arm_reg <= 1'b1;
            end else if (data_acc) begin
                arm_reg <= 1'b0;
            end
            if (done_e || ss_fault) begin
                transfer_done_flag_reg <= 1'b1;
            end else if (I_IRQ_ACK || (data_acc && arm_reg)) begin
                transfer_done_flag_reg <= 1'b0;
            end
            if (wr_data && busy) begin
                write_collision_flag_reg <= 1'b1;
            end else if (data_acc && arm_reg) begin
                write_collision_flag_reg <= 1'b0;
            end
        end
    end

    // ****************************************
    // pin drivers and interrupt
    // ****************************************
    assign O_MOSI_OUT = out_bit_reg;
    assign O_MISO_OUT = out_bit_reg;

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            O_SCK_OE   <= 1'b0;
            O_MOSI_OE  <= 1'b0;
            O_MISO_OE  <= 1'b0;
            O_SS_N_OE  <= 1'b0;
            O_SS_N_OUT <= 1'b1;
            O_IRQ      <= 1'b0;
        end else begin
            O_SCK_OE   <= !is_slv && pins_reg[spms_pkg::B_SCK_DIR];
            O_MOSI_OE  <= !is_slv && pins_reg[spms_pkg::B_MOSI_DIR];
            O_MISO_OE  <= !is_mst && pins_reg[spms_pkg::B_MISO_DIR]
                          && !(is_slv && I_SS_N_IN);
            O_SS_N_OE  <= !is_slv && pins_reg[spms_pkg::B_SS_DIR];
            O_SS_N_OUT <= pins_reg[spms_pkg::B_SS_LVL];
            O_IRQ      <= transfer_done_flag_reg && ctrl_reg[spms_pkg::B_IE]
                          && I_GLOBAL_IRQ_EN;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RST);

    sequence s_start_fast;
        start && ctrl_reg[1:0] == 2'b00 && !dbl_reg;
    endsequence

    sequence s_byte_end;
        st_reg == spms_pkg::ST_IDLE && transfer_done_flag_reg;
    endsequence

    chk_fault_drops_mst: assert property (ss_fault |=> !ctrl_reg[spms_pkg::B_MST])
        else $error("master select kept after select fault");
    chk_fault_sets_flag: assert property (ss_fault |=> transfer_done_flag_reg)
        else $error("done flag not set after select fault");
    chk_slave_ss_input: assert property (is_slv |=> !O_SS_N_OE)
        else $error("select pin driven in slave mode");
    chk_deselect_clear: assert property (is_slv && I_SS_N_IN |=> cnt_reg == 4'h0)
        else $error("bit counter kept while deselected");
    chk_miso_passive: assert property (is_slv && I_SS_N_IN |=> !O_MISO_OE)
        else $error("miso driven while deselected");
    chk_irq_gate: assert property (O_IRQ |-> $past(transfer_done_flag_reg && I_GLOBAL_IRQ_EN))
        else $error("interrupt without flag and global enable");
    chk_write_collision_flag_set: assert property (wr_data && busy |=> write_collision_flag_reg)
        else $error("collision flag not set");
    chk_byte_time: assert property (s_start_fast |-> ##[32:34] s_byte_end)
        else $error("fast byte did not end on time");
    chk_slave_no_tick: assert property (!is_mst |=> st_reg == spms_pkg::ST_IDLE)
        else $error("serial clock generator running outside master");
    chk_idle_level: assert property (
        st_reg == spms_pkg::ST_IDLE ##1 st_reg == spms_pkg::ST_IDLE && $stable(clock_idle_high)
        |-> O_SCK_OUT == clock_idle_high)
        else $error("serial clock not at idle level");
    chk_ack_clears: assert property (I_IRQ_ACK && !done_e && !ss_fault |=> !transfer_done_flag_reg)
        else $error("ack did not clear done flag");

endmodule

//--- dv/spms_peer.sv
`timescale 1ns/100ps
// ****************************************
// far-side serial slave model
// ****************************************
module spms_peer (
    // serial side
    input  wire logic       i_sck,
    input  wire logic       i_mosi,
    input  wire logic       i_ss_n,
    output logic            o_miso,
    // setup
    input  wire logic [1:0] i_mode,
    input  wire logic       i_lsb,
    input  wire logic [7:0] i_tx,
    output logic      [7:0] o_rx
);
    int   n;
    logic bit_q;

    function automatic logic pick(input int k);
        return i_lsb ? i_tx[k & 7] : i_tx[7 - (k & 7)];
    endfunction

    // released line shows the inverse of the last bit
    assign o_miso = i_ss_n ? ~bit_q : bit_q;

    always @(negedge i_ss_n) begin
        n = 0;
        bit_q = pick(0);
    end

    always @(i_sck) begin
        if (!i_ss_n) begin
            if ((i_sck != i_mode[1]) ^ i_mode[0]) begin
                o_rx = i_lsb ? {i_mosi, o_rx[7:1]} : {o_rx[6:0], i_mosi};
                n = n + 1;
            end else begin
                bit_q = pick(n);
            end
        end
    end
endmodule

//--- dv/spms_port_tb.sv
`timescale 1ns/100ps
module spms_port_tb;
    logic        clk, rst, hsel, hwrite, hready, hresp, gie, ack, irq;
    logic        tb_sck, tb_mosi, tb_ss, lsb, dbl, sck_q;
    logic        sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_o, ss_oe;
    logic        p_miso;
    wire  logic  sck, mosi, miso, ss_n;
    logic [1:0]  htrans, mode, r;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [7:0]  ptx, prx, b, got;
    int          err_count, samples_checked, tog, gap, lastgap, t0;

    assign sck  = sck_oe ? sck_o : tb_sck;
    assign mosi = mosi_oe ? mosi_o : tb_mosi;
    assign miso = miso_oe ? miso_o : p_miso;
    assign ss_n = ss_oe ? ss_o : tb_ss;

    spms_port dut (
        .I_SYS_CLK(clk), .I_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
        .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
        .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
        .I_GLOBAL_IRQ_EN(gie), .I_IRQ_ACK(ack), .O_IRQ(irq),
        .I_SCK_IN(sck), .O_SCK_OUT(sck_o), .O_SCK_OE(sck_oe),
        .I_MOSI_IN(mosi), .O_MOSI_OUT(mosi_o), .O_MOSI_OE(mosi_oe),
        .I_MISO_IN(miso), .O_MISO_OUT(miso_o), .O_MISO_OE(miso_oe),
        .I_SS_N_IN(ss_n), .O_SS_N_OUT(ss_o), .O_SS_N_OE(ss_oe)
    );

    spms_peer peer (
        .i_sck(sck), .i_mosi(mosi), .i_ss_n(ss_n), .o_miso(p_miso),
        .i_mode(mode), .i_lsb(lsb), .i_tx(ptx), .o_rx(prx)
    );

    always #4 clk = ~clk;

    // serial clock toggle counter and spacing
    always @(posedge clk) begin
        sck_q <= sck_o;
        gap <= gap + 1;
        if (sck_o !== sck_q) begin
            tog <= tog + 1;
            lastgap <= gap;
            gap <= 1;
        end
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
        chk(hresp, 32'h0);
    endtask

    task automatic wait16(input int s);
        for (int c = 0; c < 3000 && tog - s < 16; c++) @(posedge clk);
        repeat (4) @(posedge clk);
    endtask

    task automatic sbits(input int n, input logic [7:0] d);
        for (int k = 0; k < n; k++) begin
            @(posedge clk);
            tb_mosi <= d[7-k];
            repeat (4) @(posedge clk);
            got = {got[6:0], miso};
            tb_sck <= 1'b1;
            repeat (4) @(posedge clk);
            tb_sck <= 1'b0;
        end
        repeat (4) @(posedge clk);
    endtask

    function automatic int half(input logic [1:0] rs, input logic d);
        return (d ? spms_pkg::DIV_DBL[rs] : spms_pkg::DIV_NORM[rs]) / 2;
    endfunction

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #600000;
        err_count++;
        $display("watchdog expired");
        tally_and_finish;
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        clk = 0;
        rst = 1;
        {hsel, hwrite, gie, ack, tb_sck, tb_mosi, lsb, dbl, sck_q} = '0;
        tb_ss = 1;
        {htrans, mode, haddr, hwdata, ptx} = '0;
        {err_count, samples_checked, tog, gap, lastgap} = '0;
        void'($urandom(57));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rdc(spms_pkg::A_CTRL, {24'h0, spms_pkg::CTRL_RST});
        rdc(spms_pkg::A_PINS, {27'h0, spms_pkg::PINS_RST});
        rdc(spms_pkg::A_STAT, 32'h0);
        rdc(8'h20, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            r = i[1:0];
            dbl = i[0] ^ i[3];
            b = $urandom;
            @(posedge clk);
            mode <= i[3:2];
            lsb <= $urandom;
            ptx <= $urandom;
            wr(spms_pkg::A_PINS, 32'h1d);
            wr(spms_pkg::A_STAT, {31'h0, dbl});
            wr(spms_pkg::A_CTRL, {24'h0, 2'b01, lsb, 1'b1, mode, r});
            wr(spms_pkg::A_PINS, 32'h0d);
            repeat (2) @(posedge clk);
            chk({sck_oe, ss_o}, 2'b10);
            t0 = tog;
            wr(spms_pkg::A_DATA, {24'h0, b});
            wait16(t0);
            chk(tog - t0, 16);
            chk(lastgap, half(r, dbl));
            chk(sck_o, mode[1]);
            chk(prx, b);
            rdc(spms_pkg::A_STAT, {24'h0, 2'b10, 5'h0, dbl});
            rdc(spms_pkg::A_DATA, {24'h0, ptx});
            rdc(spms_pkg::A_STAT, {31'h0, dbl});
        end
        $display("test master done");
        t0 = tog;
        wr(spms_pkg::A_DATA, 32'h3c);
        wr(spms_pkg::A_DATA, 32'hc3);
        wait16(t0);
        chk(prx, 8'h3c);
        rdc(spms_pkg::A_STAT, {24'h0, 2'b11, 5'h0, dbl});
        rdc(spms_pkg::A_DATA, {24'h0, ptx});
        rdc(spms_pkg::A_STAT, {31'h0, dbl});
        wr(spms_pkg::A_CTRL, 32'h10);
        repeat (3) @(posedge clk);
        t0 = tog;
        wr(spms_pkg::A_DATA, 32'h55);
        repeat (40) @(posedge clk);
        chk(tog - t0, 0);
        $display("test collision done");
        wr(spms_pkg::A_PINS, 32'h05);
        wr(spms_pkg::A_CTRL, 32'hd0);
        gie <= 1'b1;
        repeat (3) @(posedge clk);
        tb_ss <= 1'b0;
        repeat (4) @(posedge clk);
        chk(irq, 1'b1);
        chk({sck_oe, mosi_oe}, 2'b00);
        tb_ss <= 1'b1;
        rdc(spms_pkg::A_CTRL, 32'hc0);
        gie <= 1'b0;
        repeat (3) @(posedge clk);
        chk(irq, 1'b0);
        ack <= 1'b1;
        gie <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        repeat (3) @(posedge clk);
        chk(irq, 1'b0);
        rdc(spms_pkg::A_STAT, {31'h0, dbl});
        $display("test fallback done");
        wr(spms_pkg::A_PINS, 32'h02);
        wr(spms_pkg::A_CTRL, 32'h43);
        wr(spms_pkg::A_DATA, 32'ha6);
        sbits(8, 8'hff);
        chk({miso_oe, ss_oe, sck_oe, mosi_oe}, 4'h0);
        rdc(spms_pkg::A_STAT, {31'h0, dbl});
        tb_ss <= 1'b0;
        sbits(3, 8'h81);
        chk({miso_oe, ss_oe, sck_oe, mosi_oe}, 4'h8);
        tb_ss <= 1'b1;
        wr(spms_pkg::A_DATA, 32'ha6);
        tb_ss <= 1'b0;
        sbits(8, 8'h5a);
        chk(got, 8'ha6);
        rdc(spms_pkg::A_DATA, 32'h5a);
        tb_ss <= 1'b1;
        $display("test slave done");
        tally_and_finish;
    end
endmodule
